// File: shared/dae_pkg.sv
/*
  Shared constants and carrier types of the dual alarm event detector:
  register offsets, field positions, reset values and source layout.
  Assumes a 16-bit register port driven by the serial interface front end.
*/
package dae_pkg;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] DAE_FLASH_CNT_OFF = 8'h00;
  localparam logic [7:0] DAE_THR1_OFF = 8'h20;
  localparam logic [7:0] DAE_THR2_OFF = 8'h22;
  localparam logic [7:0] DAE_SMPL1_OFF = 8'h24;
  localparam logic [7:0] DAE_SMPL2_OFF = 8'h26;
  localparam logic [7:0] DAE_CTRL_OFF = 8'h28;
  localparam logic [7:0] DAE_STATUS_OFF = 8'h3C;

  // ------------------------------------------------------------
  // widths, fields and reset values
  // ------------------------------------------------------------
  localparam int DAE_DATA_W = 14;
  localparam int DAE_NUM_SRC = 8;
  localparam int DAE_SEL_W = 3;
  localparam int DAE_SUM_W = 23;
  localparam int DAE_FLASH_W = 15;
  localparam int DAE_THR_DIR_BIT = 15;
  localparam int DAE_THR_MAG_MSB = 13;
  localparam int DAE_SMPL_MSB = 7;
  localparam int DAE_STAT_ALM1_BIT = 8;
  localparam int DAE_STAT_ALM2_BIT = 9;
  localparam int DAE_CTRL_ALM1_LSB = 0;
  localparam int DAE_CTRL_ALM2_LSB = 8;
  localparam logic [15:0] DAE_REG_RST = 16'h0000;
  localparam logic [14:0] DAE_FLASH_RST = 15'h0000;

  // per-alarm control byte, alarm 1 in bits 7:0, alarm 2 in bits 15:8
  typedef struct packed {
    logic dio_line_two;
    logic dio_en;
    logic filtered;
    logic dynamic;
    logic spare;
    logic [DAE_SEL_W-1:0] src_sel;
  } dae_alm_cfg_t;

  // one output data register as seen by the alarms
  typedef struct packed {
    logic [DAE_DATA_W-1:0] filt;
    logic [DAE_DATA_W-1:0] raw;
    logic upd;
  } dae_src_t;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } dae_reg_req_t;

endpackage

// File: src/dae_alarm_chan.sv
/*
  One alarm channel: static or rate-of-change comparison of a 14-bit
  two's complement sample against a signed threshold magnitude.
  Assumes the sample and its valid strobe come from same-clock logic.
*/
`timescale 1ns/1ps
module dae_alarm_chan
  import dae_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // configuration
  input wire logic restart_i,
  input wire logic dynamic_i,
  input wire logic [15:0] thresh_i,
  input wire logic [7:0] nsamp_i,
  // sample
  input wire logic [DAE_DATA_W-1:0] sample_i,
  input wire logic sample_vld_i,
  // result
  output logic event_o,
  output logic active_o
);

  logic [DAE_DATA_W-1:0] prev_q, prev_d;
  logic have_prev_q, have_prev_d;
  logic signed [DAE_SUM_W-1:0] sum_q, sum_d;
  logic [7:0] cnt_q, cnt_d;
  logic event_q, event_d;
  logic active_q, active_d;

  logic signed [DAE_SUM_W-1:0] delta;
  logic signed [DAE_SUM_W-1:0] acc;
  logic signed [DAE_SUM_W-1:0] avg;
  logic signed [DAE_SUM_W-1:0] thr;
  logic signed [DAE_SUM_W-1:0] val;
  logic signed [DAE_SUM_W-1:0] div;
  logic [7:0] target;
  logic eval;
  logic hit;

  // ------------------------------------------------------------
  // comparison datapath
  // ------------------------------------------------------------
  always_comb begin
    // a zero count would divide by zero; treat it as one delta
    target = (nsamp_i[DAE_SMPL_MSB:0] == 8'h00) ? 8'h01 : nsamp_i[DAE_SMPL_MSB:0]; // RL11
    delta = DAE_SUM_W'($signed(sample_i)) - DAE_SUM_W'($signed(prev_q)); // RL12
    acc = sum_q + delta;
    div = $signed({{(DAE_SUM_W-8){1'b0}}, target});
    avg = acc / div; // RL13
    thr = DAE_SUM_W'($signed(thresh_i[DAE_THR_MAG_MSB:0])); // RL9
    val = dynamic_i ? avg : DAE_SUM_W'($signed(sample_i)); // RL7
    hit = thresh_i[DAE_THR_DIR_BIT] ? (val > thr) : (val < thr); // RL10
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    prev_d = prev_q;
    have_prev_d = have_prev_q;
    sum_d = sum_q;
    cnt_d = cnt_q;
    event_d = 1'b0;
    active_d = active_q;
    eval = 1'b0;
    if (restart_i) begin
      // settings changed: drop the partial average
      have_prev_d = 1'b0;
      sum_d = '0;
      cnt_d = 8'h00;
      active_d = 1'b0;
    end else if (sample_vld_i) begin // RL17
      prev_d = sample_i;
      have_prev_d = 1'b1;
      if (!dynamic_i) begin
        eval = 1'b1;
      end else if (have_prev_q) begin
        if (cnt_q + 8'h01 >= target) begin
          eval = 1'b1;
          sum_d = '0;
          cnt_d = 8'h00;
        end else begin
          sum_d = acc;
          cnt_d = cnt_q + 8'h01;
        end
      end
      if (eval) begin
        event_d = hit; // RL4
        active_d = hit;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_q <= '0;
      have_prev_q <= 1'b0;
      sum_q <= '0;
      cnt_q <= 8'h00;
      event_q <= 1'b0;
      active_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      have_prev_q <= have_prev_d;
      sum_q <= sum_d;
      cnt_q <= cnt_d;
      event_q <= event_d;
      active_q <= active_d;
    end
  end

  assign event_o = event_q;
  assign active_o = active_q;

endmodule

// File: src/dae_detector.sv
/*
  Top of the dual alarm event detector: register file, flash write
  counter, source selection, status flags and digital line drive.
  Assumes the serial front end presents one-cycle read and write strobes
  on the same clock and that output data registers arrive with strobes.
*/
`timescale 1ns/1ps

// Functional notes
// RL1 - count every flash write, 32768 counts
// RL2 - counter wraps to zero past maximum
// RL3 - two independent alarm channels
// RL4 - event when source meets configured condition
// RL5 - any output data register selectable
// RL6 - filtered or unfiltered source per alarm
// RL7 - static value or dynamic rate comparison
// RL8 - own threshold and sample count each
// RL9 - threshold bits 13:0 magnitude, 14 unused
// RL10 - threshold bit 15 picks direction
// RL11 - sample count bits 7:0, upper unused
// RL12 - delta is next minus previous sample
// RL13 - average deltas then compare to threshold
// RL14 - shared control picks source, mode, filter, lines
// RL15 - status bit 9 alarm two, 8 alarm one
// RL16 - status sticky until read, read clears all
// RL17 - re-evaluate on each source update; in dynamic mode the code compares only after each full sample count of deltas
// RL18 - routed line asserted while alarm active
module dae_detector
  import dae_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // register port
  input wire dae_reg_req_t reg_req_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // output data registers under watch
  input wire dae_src_t [DAE_NUM_SRC-1:0] src_i,
  // flash controller
  input wire logic flash_write_i,
  input wire logic flash_restore_i,
  input wire logic [15:0] flash_restore_val_i,
  // digital lines
  output logic general_io_line_one_o,
  output logic general_io_line_two_o,
  output logic alarm1_active_o,
  output logic alarm2_active_o
);

  logic [15:0] thr1_q, thr1_d;
  logic [15:0] thr2_q, thr2_d;
  logic [15:0] smpl1_q, smpl1_d;
  logic [15:0] smpl2_q, smpl2_d;
  logic [15:0] ctrl_q, ctrl_d;
  logic [DAE_FLASH_W-1:0] flash_cnt_q, flash_cnt_d;
  logic alm1_stat_q, alm1_stat_d;
  logic alm2_stat_q, alm2_stat_d;
  logic [15:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic line_one_q, line_one_d;
  logic line_two_q, line_two_d;

  dae_alm_cfg_t cfg1, cfg2;
  dae_src_t sel1, sel2;
  logic [DAE_DATA_W-1:0] smp1, smp2;
  logic restart1, restart2;
  logic ev1, ev2;
  logic act1, act2;
  logic stat_rd;
  logic [15:0] status_word;
  logic wr_thr1, wr_thr2, wr_smpl1, wr_smpl2, wr_ctrl;
  logic ctrl1_chg, ctrl2_chg;

  // ------------------------------------------------------------
  // register write decode
  // ------------------------------------------------------------
  always_comb begin
    wr_thr1 = reg_req_i.wr && (reg_req_i.addr == DAE_THR1_OFF);
    wr_thr2 = reg_req_i.wr && (reg_req_i.addr == DAE_THR2_OFF);
    wr_smpl1 = reg_req_i.wr && (reg_req_i.addr == DAE_SMPL1_OFF);
    wr_smpl2 = reg_req_i.wr && (reg_req_i.addr == DAE_SMPL2_OFF);
    wr_ctrl = reg_req_i.wr && (reg_req_i.addr == DAE_CTRL_OFF);
    // rewriting a control byte with its old value leaves that channel running
    ctrl1_chg = wr_ctrl && (reg_req_i.wdata[DAE_CTRL_ALM1_LSB +: 8] != ctrl_q[DAE_CTRL_ALM1_LSB +: 8]);
    ctrl2_chg = wr_ctrl && (reg_req_i.wdata[DAE_CTRL_ALM2_LSB +: 8] != ctrl_q[DAE_CTRL_ALM2_LSB +: 8]);
  end

  // ------------------------------------------------------------
  // control decode and source selection
  // ------------------------------------------------------------
  always_comb begin
    cfg1 = dae_alm_cfg_t'(ctrl_q[DAE_CTRL_ALM1_LSB +: 8]); // RL14
    cfg2 = dae_alm_cfg_t'(ctrl_q[DAE_CTRL_ALM2_LSB +: 8]); // RL14
    sel1 = src_i[cfg1.src_sel]; // RL5
    sel2 = src_i[cfg2.src_sel]; // RL5
    smp1 = cfg1.filtered ? sel1.filt : sel1.raw; // RL6
    smp2 = cfg2.filtered ? sel2.filt : sel2.raw; // RL6
    // a change to any setting of a channel restarts its averaging
    restart1 = wr_thr1 || wr_smpl1 || ctrl1_chg;
    restart2 = wr_thr2 || wr_smpl2 || ctrl2_chg;
  end

  // ------------------------------------------------------------
  // alarm channels
  // ------------------------------------------------------------
  dae_alarm_chan u_alarm1 ( // RL3
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .restart_i(restart1),
    .dynamic_i(cfg1.dynamic),
    .thresh_i(thr1_q), // RL8
    .nsamp_i(smpl1_q[7:0]), // RL8
    .sample_i(smp1),
    .sample_vld_i(sel1.upd), // RL17
    .event_o(ev1),
    .active_o(act1)
  );

  dae_alarm_chan u_alarm2 ( // RL3
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .restart_i(restart2),
    .dynamic_i(cfg2.dynamic),
    .thresh_i(thr2_q), // RL8
    .nsamp_i(smpl2_q[7:0]), // RL8
    .sample_i(smp2),
    .sample_vld_i(sel2.upd), // RL17
    .event_o(ev2),
    .active_o(act2)
  );

  // ------------------------------------------------------------
  // register file next state
  // ------------------------------------------------------------
  always_comb begin
    thr1_d = thr1_q;
    thr2_d = thr2_q;
    smpl1_d = smpl1_q;
    smpl2_d = smpl2_q;
    ctrl_d = ctrl_q;
    if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        DAE_THR1_OFF: begin
          thr1_d = reg_req_i.wdata & 16'hBFFF; // RL9
        end
        DAE_THR2_OFF: begin
          thr2_d = reg_req_i.wdata & 16'hBFFF; // RL9
        end
        DAE_SMPL1_OFF: begin
          smpl1_d = reg_req_i.wdata & 16'h00FF; // RL11
        end
        DAE_SMPL2_OFF: begin
          smpl2_d = reg_req_i.wdata & 16'h00FF; // RL11
        end
        DAE_CTRL_OFF: begin
          ctrl_d = reg_req_i.wdata;
        end
        default: begin
          ctrl_d = ctrl_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      thr1_q <= DAE_REG_RST;
      thr2_q <= DAE_REG_RST;
      smpl1_q <= DAE_REG_RST;
      smpl2_q <= DAE_REG_RST;
      ctrl_q <= DAE_REG_RST;
    end else begin
      thr1_q <= thr1_d;
      thr2_q <= thr2_d;
      smpl1_q <= smpl1_d;
      smpl2_q <= smpl2_d;
      ctrl_q <= ctrl_d;
    end
  end

  // ------------------------------------------------------------
  // flash write counter
  // ------------------------------------------------------------
  always_comb begin
    flash_cnt_d = flash_cnt_q;
    if (flash_restore_i) begin
      // count held in flash is reloaded at power up; it survives resets that way
      flash_cnt_d = flash_restore_val_i[DAE_FLASH_W-1:0];
    end else if (flash_write_i) begin
      flash_cnt_d = flash_cnt_q + 15'h0001; // RL1 RL2
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flash_cnt_q <= DAE_FLASH_RST;
    end else begin
      flash_cnt_q <= flash_cnt_d;
    end
  end

  // ------------------------------------------------------------
  // status flags
  // ------------------------------------------------------------
  always_comb begin
    stat_rd = reg_req_i.rd && (reg_req_i.addr == DAE_STATUS_OFF);
    status_word = 16'h0000;
    status_word[DAE_STAT_ALM1_BIT] = alm1_stat_q; // RL15
    status_word[DAE_STAT_ALM2_BIT] = alm2_stat_q; // RL15
    // a new event in the cycle of the clearing read is kept
    alm1_stat_d = ev1 ? 1'b1 : (stat_rd ? 1'b0 : alm1_stat_q); // RL16
    alm2_stat_d = ev2 ? 1'b1 : (stat_rd ? 1'b0 : alm2_stat_q); // RL16
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      alm1_stat_q <= 1'b0;
      alm2_stat_q <= 1'b0;
    end else begin
      alm1_stat_q <= alm1_stat_d;
      alm2_stat_q <= alm2_stat_d;
    end
  end

  // ------------------------------------------------------------
  // register read path
  // ------------------------------------------------------------
  always_comb begin
    rvalid_d = reg_req_i.rd;
    rdata_d = rdata_q;
    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        DAE_FLASH_CNT_OFF: begin
          rdata_d = {1'b0, flash_cnt_q};
        end
        DAE_THR1_OFF: begin
          rdata_d = thr1_q;
        end
        DAE_THR2_OFF: begin
          rdata_d = thr2_q;
        end
        DAE_SMPL1_OFF: begin
          rdata_d = smpl1_q;
        end
        DAE_SMPL2_OFF: begin
          rdata_d = smpl2_q;
        end
        DAE_CTRL_OFF: begin
          rdata_d = ctrl_q;
        end
        DAE_STATUS_OFF: begin
          rdata_d = status_word;
        end
        default: begin
          rdata_d = 16'h0000;
        end
      endcase
    end
  end

  // read data holds between reads so a slow front end can fetch it late
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ------------------------------------------------------------
  // digital line drive
  // ------------------------------------------------------------
  always_comb begin
    line_one_d = (cfg1.dio_en && !cfg1.dio_line_two && act1) ||
                 (cfg2.dio_en && !cfg2.dio_line_two && act2); // RL18
    line_two_d = (cfg1.dio_en && cfg1.dio_line_two && act1) ||
                 (cfg2.dio_en && cfg2.dio_line_two && act2); // RL18
  end

  // registered lines trail the alarm state by one cycle but never glitch
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      line_one_q <= 1'b0;
      line_two_q <= 1'b0;
    end else begin
      line_one_q <= line_one_d;
      line_two_q <= line_two_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign reg_rvalid_o = rvalid_q;
  assign general_io_line_one_o = line_one_q;
  assign general_io_line_two_o = line_two_q;
  assign alarm1_active_o = act1;
  assign alarm2_active_o = act2;

endmodule

// File: test/dae_checker.sv
/*
  Checker bound to dae_detector: register readback, status layout,
  line routing and alarm update timing. Assumes same-clock strobes.
*/
`timescale 1ns/1ps
module dae_checker
  import dae_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // register port
  input wire dae_reg_req_t reg_req_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  // sources and results
  input wire dae_src_t [DAE_NUM_SRC-1:0] src_i,
  input wire logic general_io_line_one_o,
  input wire logic general_io_line_two_o,
  input wire logic alarm1_active_o,
  input wire logic alarm2_active_o
);
  // ----------------
  // shadow state
  // ----------------
  logic [15:0] ctrl_q, ctrl_d, thr1_q, thr1_d;
  logic upd_any, route1, route2, rd_q;
  logic [7:0] a;
  assign a = reg_req_i.addr;
  assign rd_q = reg_req_i.rd;
  always_comb begin
    ctrl_d = ctrl_q;
    thr1_d = thr1_q;
    if (reg_req_i.wr && a == DAE_CTRL_OFF) begin
      ctrl_d = reg_req_i.wdata;
    end
    if (reg_req_i.wr && a == DAE_THR1_OFF) begin
      thr1_d = reg_req_i.wdata & 16'hBFFF;
    end
    upd_any = 1'b0;
    for (int k = 0; k < DAE_NUM_SRC; k++) begin
      upd_any = upd_any | src_i[k].upd;
    end
    route1 = (ctrl_q[6] && !ctrl_q[7] && alarm1_active_o) || (ctrl_q[14] && !ctrl_q[15] && alarm2_active_o);
    route2 = (ctrl_q[6] && ctrl_q[7] && alarm1_active_o) || (ctrl_q[14] && ctrl_q[15] && alarm2_active_o);
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= DAE_REG_RST;
      thr1_q <= DAE_REG_RST;
    end else begin
      ctrl_q <= ctrl_d;
      thr1_q <= thr1_d;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  property p_ctrl; rd_q && a == DAE_CTRL_OFF |=> reg_rdata_o == $past(ctrl_q); endproperty
  a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
  property p_thr1; rd_q && a == DAE_THR1_OFF |=> reg_rdata_o == $past(thr1_q); endproperty
  a_thr1: assert property (p_thr1) else $error("threshold readback wrong");
  property p_smpl; rd_q && (a == DAE_SMPL1_OFF || a == DAE_SMPL2_OFF) |=> reg_rdata_o[15:8] == 8'h00; endproperty
  a_smpl: assert property (p_smpl) else $error("sample count upper byte set");
  property p_stat; rd_q && a == DAE_STATUS_OFF |=> reg_rvalid_o && reg_rdata_o[15:10] == 6'h00 && reg_rdata_o[7:0] == 8'h00; endproperty
  a_stat: assert property (p_stat) else $error("status layout wrong");
  property p_unmap; rd_q && a == 8'h30 |=> reg_rvalid_o && reg_rdata_o == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_line1; general_io_line_one_o == $past(route1); endproperty
  a_line1: assert property (p_line1) else $error("line one routing wrong");
  property p_line2; general_io_line_two_o == $past(route2); endproperty
  a_line2: assert property (p_line2) else $error("line two routing wrong");
  property p_act; $changed(alarm1_active_o) || $changed(alarm2_active_o) |-> $past(upd_any || reg_req_i.wr); endproperty
  a_act: assert property (p_act) else $error("alarm changed without update");
  c_line1: cover property (general_io_line_one_o);
  c_line2: cover property (general_io_line_two_o);
  c_stat: cover property (reg_rvalid_o && reg_rdata_o[9:8] == 2'b11);
endmodule

bind dae_detector dae_checker u_dae_checker (
  .clk_i(clk_i),
  .resetn_i(resetn_i),
  .reg_req_i(reg_req_i),
  .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o),
  .src_i(src_i),
  .general_io_line_one_o(general_io_line_one_o),
  .general_io_line_two_o(general_io_line_two_o),
  .alarm1_active_o(alarm1_active_o),
  .alarm2_active_o(alarm2_active_o)
);

// File: test/dae_detector_tb_top.sv
/*
  Testbench: register access, flash count wrap, static and averaged
  alarms. Assumes the host model owns the register port.
*/
`timescale 1ns/1ps
module dae_detector_tb_top
  import dae_pkg::*;
;
  logic clk_i, resetn_i, fl_wr, fl_ld, rv, l1, l2, a1, a2;
  logic [15:0] fl_val, rd, rdat, pins;
  dae_reg_req_t req;
  dae_src_t [DAE_NUM_SRC-1:0] src;
  logic [7:0] offs [8] = '{8'h00, 8'h20, 8'h22, 8'h24, 8'h26, 8'h28, 8'h3C, 8'h30};
  int fails = 0;
  int cmp_count = 0;
  assign pins = {12'h000, a2, a1, l2, l1};
  dae_detector uut (.clk_i(clk_i), .resetn_i(resetn_i), .reg_req_i(req), .reg_rdata_o(rdat),
    .reg_rvalid_o(rv), .src_i(src), .flash_write_i(fl_wr), .flash_restore_i(fl_ld),
    .flash_restore_val_i(fl_val), .general_io_line_one_o(l1), .general_io_line_two_o(l2),
    .alarm1_active_o(a1), .alarm2_active_o(a2));
  dae_host_model host (.clk_i(clk_i), .reg_req_o(req), .reg_rdata_i(rdat), .reg_rvalid_i(rv));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [15:0] exp);
    host.rd_reg(ad, rd);
    check(rd, exp);
  endtask
  // whole-vector writes keep the automatic index out of the nonblocking target
  task automatic smp(input int k, input logic [13:0] raw, input logic [13:0] filt);
    dae_src_t [DAE_NUM_SRC-1:0] nxt;
    @(posedge clk_i);
    nxt = src;
    nxt[k] = '{filt, raw, 1'b1};
    src <= nxt;
    @(posedge clk_i);
    nxt[k].upd = 1'b0;
    src <= nxt;
  endtask
  task automatic after(input logic [15:0] exp);
    repeat (2) @(posedge clk_i);
    #1 check(pins, exp);
  endtask
  task automatic fl(input logic w, input logic ld);
    @(posedge clk_i);
    fl_wr <= w;
    fl_ld <= ld;
    @(posedge clk_i);
    fl_wr <= 1'b0;
    fl_ld <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----------------
  // test sequence
  // ----------------
  initial begin
    resetn_i = 1'b0;
    fl_wr = 1'b0;
    fl_ld = 1'b0;
    fl_val = 16'h7FFE;
    src = '0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    foreach (offs[i]) rchk(offs[i], 16'h0000);
    host.wr_reg(DAE_THR1_OFF, 16'hFFFF);
    rchk(DAE_THR1_OFF, 16'hBFFF);
    rchk(DAE_THR2_OFF, 16'h0000);
    host.wr_reg(DAE_SMPL2_OFF, 16'hFFFF);
    rchk(DAE_SMPL2_OFF, 16'h00FF);
    rchk(DAE_SMPL1_OFF, 16'h0000);
    fl(1'b0, 1'b1);
    fl(1'b1, 1'b0);
    rchk(DAE_FLASH_CNT_OFF, 16'h7FFF);
    fl(1'b1, 1'b0);
    rchk(DAE_FLASH_CNT_OFF, 16'h0000);
    // alarm 1 raw src 2 above 100 on line one, alarm 2 filtered src 5 below -50 on line two
    host.wr_reg(DAE_THR1_OFF, 16'h8064);
    host.wr_reg(DAE_THR2_OFF, 16'h3FCE);
    host.wr_reg(DAE_CTRL_OFF, 16'hE542);
    smp(2, 14'h00C8, 14'h0000);
    smp(5, 14'h0000, 14'h3F9C);
    after(16'h000F);
    rchk(DAE_STATUS_OFF, 16'h0300);
    rchk(DAE_STATUS_OFF, 16'h0000);
    smp(5, 14'h3F9C, 14'h0000);
    smp(3, 14'h01F4, 14'h0000);
    after(16'h0005);
    smp(2, 14'h0032, 14'h0000);
    after(16'h0000);
    // averaged deltas over two samples against +5
    host.wr_reg(DAE_SMPL1_OFF, 16'h0002);
    host.wr_reg(DAE_THR1_OFF, 16'h8005);
    host.wr_reg(DAE_CTRL_OFF, 16'h0012);
    smp(2, 14'h0000, 14'h0000);
    smp(2, 14'h000A, 14'h0000);
    smp(2, 14'h0016, 14'h0000);
    after(16'h0004);
    rchk(DAE_STATUS_OFF, 16'h0100);
    smp(2, 14'h0018, 14'h0000);
    smp(2, 14'h001A, 14'h0000);
    after(16'h0000);
    // mid-run reset returns every setting to zero
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    rchk(DAE_SMPL1_OFF, 16'h0000);
    rchk(DAE_THR1_OFF, 16'h0000);
    rchk(DAE_CTRL_OFF, 16'h0000);
    tally_and_finish();
  end
  initial begin
    #50000;
    fails++;
    tally_and_finish();
  end
endmodule

// File: test/dae_host_model.sv
/*
  Host model: drives the register port as the serial front end does.
  Assumes read data arrives one cycle after the read strobe.
*/
`timescale 1ns/1ps
module dae_host_model
  import dae_pkg::*;
(
  // clock
  input wire logic clk_i,
  // register port
  output dae_reg_req_t reg_req_o,
  input wire logic [15:0] reg_rdata_i,
  input wire logic reg_rvalid_i
);
  initial begin
    reg_req_o = '0;
  end
  task automatic wr_reg(input logic [7:0] ad, input logic [15:0] d);
    @(posedge clk_i);
    reg_req_o <= '{1'b1, 1'b0, ad, d};
    @(posedge clk_i);
    reg_req_o <= '0;
  endtask
  // a missing valid returns unknown so the caller's compare fails
  task automatic rd_reg(input logic [7:0] ad, output logic [15:0] d);
    @(posedge clk_i);
    reg_req_o <= '{1'b0, 1'b1, ad, 16'h0000};
    @(posedge clk_i);
    reg_req_o <= '0;
    @(posedge clk_i);
    d = reg_rvalid_i ? reg_rdata_i : 16'hXXXX;
  endtask
endmodule
